/* core/rx_status_control.v */
// receive control and status logic of a serial port, apb slave with one wait state
// assumes pins arrive asynchronous to mclk_in; transmitter lives elsewhere
`timescale 1ns/1ps
`include "rx_status_control_map.vh"
module rx_status_control #(
  parameter BUF_ADDR_W = 1
)(
  input  wire        mclk_in,            // system clock 125 MHz
  input  wire        rst_in,             // synchronous reset, active high
  input  wire [7:0]  paddr_in,           // apb address
  input  wire        psel_in,            // apb select
  input  wire        penable_in,         // apb enable
  input  wire        pwrite_in,          // apb direction
  input  wire [31:0] pwdata_in,          // apb write data
  output reg  [31:0] prdata_out,         // apb read data
  output reg         pready_out,         // apb ready
  output reg         pslverr_out,        // apb error, unmapped address
  input  wire        data_pin_in,        // receive_or_sync_data_pin level
  output reg         data_pin_out,       // data pin drive value
  output reg         data_pin_oe_n_out,  // data pin enable, low drives
  input  wire        clock_pin_in,       // transmit_or_sync_clock_pin level
  output reg         clock_pin_out,      // clock pin drive value
  output reg         clock_pin_oe_n_out, // clock pin enable, low drives
  output reg         pins_assigned_out,  // pins owned by the serial port
  output reg         char_ready_out      // receive request: buffer holds a char
);

  localparam ST_IDLE  = 4'b0001;
  localparam ST_START = 4'b0010;
  localparam ST_DATA  = 4'b0100;
  localparam ST_STOP  = 4'b1000;
  localparam PTR_W    = BUF_ADDR_W + 1;
  localparam [7:0] CTL_RESET = `RESET_STATUS_CONTROL;

  function [3:0] char_bits;
    input nine;
    begin
      char_bits = nine ? `CHAR_BITS_LONG : `CHAR_BITS_SHORT;
    end
  endfunction

  // ************************************************
  // control registers and synchronisers
  // ************************************************
  reg             serial_port_enable_reg, rx9_reg, single_receive_enable_reg, continuous_receive_enable_reg, address_detect_enable_reg, overrun_error_flag_reg;
  reg             sync_reg, master_reg;
  reg  [15:0]     divisor_reg;
  reg             data_s1_reg, data_s2_reg, clk_s1_reg, clk_s2_reg, clk_s3_reg;
  reg  [3:0]      state_reg;
  reg  [15:0]     tick_reg;
  reg  [3:0]      bit_idx_reg;
  reg  [8:0]      shift_reg;
  reg             sclk_reg;
  reg  [PTR_W-1:0] wr_ptr_reg, rd_ptr_reg;
  wire [9:0]      head_data;

  wire [PTR_W-1:0] count     = wr_ptr_reg - rd_ptr_reg;
  wire             buf_empty = (count == {PTR_W{1'b0}});
  wire             buf_full  = (count == {1'b1, {BUF_ADDR_W{1'b0}}});
  wire             rx_on     = serial_port_enable_reg & ~overrun_error_flag_reg &
                               (continuous_receive_enable_reg | (sync_reg & master_reg & single_receive_enable_reg));
  wire             slave_rise = clk_s2_reg & ~clk_s3_reg;
  wire             framing_error_flag_head  = ~buf_empty & head_data[9];
  wire             ninth_head = ~buf_empty & head_data[8];

  always @(posedge mclk_in)
  begin
    data_s1_reg <= data_pin_in;
    data_s2_reg <= data_s1_reg;
    clk_s1_reg  <= clock_pin_in;
    clk_s2_reg  <= clk_s1_reg;
    clk_s3_reg  <= clk_s2_reg;
  end

  // ************************************************
  // apb slave
  // ************************************************
  wire        access = psel_in & penable_in & pready_out;
  wire        wr_now = access & pwrite_in;
  wire        rd_now = access & ~pwrite_in;
  wire        mapped = (paddr_in == `OFF_STATUS_CONTROL) | (paddr_in == `OFF_DATA_BUFFER) |
                       (paddr_in == `OFF_MODE) | (paddr_in == `OFF_BAUD_DIVISOR) |
                       (paddr_in == `OFF_ENGINE_STATUS);
  wire        wr_ctl = wr_now & (paddr_in == `OFF_STATUS_CONTROL);
  wire        pop    = rd_now & (paddr_in == `OFF_DATA_BUFFER) & ~buf_empty;
  wire [7:0]  status_byte = {serial_port_enable_reg, rx9_reg, single_receive_enable_reg, continuous_receive_enable_reg, address_detect_enable_reg,
                             framing_error_flag_head, overrun_error_flag_reg, ninth_head};
  reg  [31:0] rd_value;

  always @*
  begin
    rd_value = 32'h0000_0000;
    case (paddr_in)
      `OFF_STATUS_CONTROL: rd_value = {24'h00_0000, status_byte};
      `OFF_DATA_BUFFER:    rd_value = {24'h00_0000, buf_empty ? 8'h00 : head_data[7:0]};
      `OFF_MODE:           rd_value = {30'h0000_0000, master_reg, sync_reg};
      `OFF_BAUD_DIVISOR:   rd_value = {16'h0000, divisor_reg};
      `OFF_ENGINE_STATUS:  rd_value = {24'h00_0000, state_reg, {(4-PTR_W){1'b0}}, count};
      default:             rd_value = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end
    else
    begin
      pready_out  <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out & ~mapped;
      prdata_out  <= (psel_in & penable_in & ~pready_out & ~pwrite_in) ? rd_value
                                                                        : 32'h0000_0000;
    end
  end

  // ************************************************
  // receive engine
  // ************************************************
  reg        done;
  reg        done_framing_error_flag;
  reg [8:0]  done_word;
  wire [3:0] last_idx = char_bits(rx9_reg) - 4'h1;
  wire [8:0] shifted  = {data_s2_reg, shift_reg[8:1]};
  wire [8:0] aligned  = rx9_reg ? shifted : {1'b0, shifted[8:1]};
  wire       sample_sync = master_reg ? (tick_reg == 16'h0000 && sclk_reg) : slave_rise;

  always @(posedge mclk_in)
  begin
    done      <= 1'b0;
    done_framing_error_flag <= 1'b0;
    if (rst_in || !serial_port_enable_reg || !rx_on)
    begin
      state_reg   <= ST_IDLE;
      tick_reg    <= 16'h0000;
      bit_idx_reg <= 4'h0;
      shift_reg   <= 9'h000;
      sclk_reg    <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          bit_idx_reg <= 4'h0;
          if (sync_reg)
          begin
            state_reg <= ST_DATA;
            tick_reg  <= divisor_reg;
          end
          else if (!data_s2_reg)
          begin
            state_reg <= ST_START;
            tick_reg  <= {1'b0, divisor_reg[15:1]};
          end
        end
        ST_START:
        begin
          if (tick_reg != 16'h0000)
            tick_reg <= tick_reg - 16'h0001;
          else if (!data_s2_reg)
          begin
            state_reg <= ST_DATA;
            tick_reg  <= divisor_reg;
          end
          else
            state_reg <= ST_IDLE;
        end
        ST_DATA:
        begin
          if (sync_reg && master_reg)
          begin
            // clock idles low, data taken as the clock falls
            if (tick_reg != 16'h0000)
              tick_reg <= tick_reg - 16'h0001;
            else
            begin
              tick_reg <= divisor_reg;
              sclk_reg <= ~sclk_reg;
            end
          end
          if ((!sync_reg && tick_reg == 16'h0000) || (sync_reg && sample_sync))
          begin
            shift_reg <= shifted;
            if (!sync_reg)
              tick_reg <= divisor_reg;
            if (bit_idx_reg == last_idx)
            begin
              bit_idx_reg <= 4'h0;
              if (sync_reg)
              begin
                done      <= 1'b1;
                done_word <= aligned;
              end
              else
                state_reg <= ST_STOP;
            end
            else
              bit_idx_reg <= bit_idx_reg + 4'h1;
          end
          else if (!sync_reg)
            tick_reg <= tick_reg - 16'h0001;
        end
        ST_STOP:
        begin
          if (tick_reg != 16'h0000)
            tick_reg <= tick_reg - 16'h0001;
          else
          begin
            state_reg <= ST_IDLE;
            done      <= 1'b1;
            done_framing_error_flag <= ~data_s2_reg;
            done_word <= rx9_reg ? shift_reg : {1'b0, shift_reg[8:1]};
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ************************************************
  // character acceptance and buffer
  // ************************************************
  wire addr_mode = ~sync_reg & rx9_reg & address_detect_enable_reg;
  wire keep      = done & ~(addr_mode & ~done_word[8]);
  wire push      = keep & ~buf_full & serial_port_enable_reg;
  wire overrun   = keep & buf_full & serial_port_enable_reg;

  rx_char_memory #(
    .WIDTH  (10),
    .ADDR_W (BUF_ADDR_W)
  ) u_store (
    .mclk_in     (mclk_in),
    .wr_en_in    (push),
    .wr_addr_in  (wr_ptr_reg[BUF_ADDR_W-1:0]),
    .wr_data_in  ({done_framing_error_flag, done_word}),
    .rd_addr_in  (rd_ptr_reg[BUF_ADDR_W-1:0]),
    .rd_data_out (head_data)
  );

  always @(posedge mclk_in)
  begin
    if (rst_in || !serial_port_enable_reg)
    begin
      wr_ptr_reg <= {PTR_W{1'b0}};
      rd_ptr_reg <= {PTR_W{1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + {{(PTR_W-1){1'b0}}, 1'b1};
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + {{(PTR_W-1){1'b0}}, 1'b1};
    end
  end

  // ************************************************
  // control register writes and hardware updates
  // ************************************************
  wire continuous_receive_enable_after = wr_ctl ? pwdata_in[`BIT_CONT_ENABLE] : continuous_receive_enable_reg;

  always @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      serial_port_enable_reg    <= CTL_RESET[`BIT_PORT_ENABLE];
      rx9_reg     <= 1'b0;
      single_receive_enable_reg    <= 1'b0;
      continuous_receive_enable_reg    <= 1'b0;
      address_detect_enable_reg   <= 1'b0;
      overrun_error_flag_reg    <= 1'b0;
      sync_reg    <= 1'b0;
      master_reg  <= 1'b0;
      divisor_reg <= `RESET_BAUD_DIVISOR;
    end
    else
    begin
      if (wr_ctl)
      begin
        serial_port_enable_reg  <= pwdata_in[`BIT_PORT_ENABLE];
        rx9_reg   <= pwdata_in[`BIT_NINE_SELECT];
        continuous_receive_enable_reg  <= pwdata_in[`BIT_CONT_ENABLE];
        address_detect_enable_reg <= pwdata_in[`BIT_ADDR_DETECT];
      end
      if (wr_ctl)
        single_receive_enable_reg <= pwdata_in[`BIT_SINGLE_ENABLE];
      else if (done && sync_reg && master_reg && !continuous_receive_enable_reg)
        single_receive_enable_reg <= 1'b0;
      // overrun set wins over a simultaneous clear of continuous enable
      if (overrun)
        overrun_error_flag_reg <= 1'b1;
      else if (!continuous_receive_enable_after || !serial_port_enable_reg)
        overrun_error_flag_reg <= 1'b0;
      if (wr_now && paddr_in == `OFF_MODE)
      begin
        sync_reg   <= pwdata_in[`BIT_MODE_SYNC];
        master_reg <= pwdata_in[`BIT_MODE_MASTER];
      end
      if (wr_now && paddr_in == `OFF_BAUD_DIVISOR)
        divisor_reg <= pwdata_in[15:0];
    end
  end

  // ************************************************
  // pin control outputs
  // ************************************************
  always @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      pins_assigned_out  <= 1'b0;
      clock_pin_out      <= 1'b0;
      clock_pin_oe_n_out <= 1'b1;
      data_pin_out       <= 1'b0;
      data_pin_oe_n_out  <= 1'b1;
      char_ready_out     <= 1'b0;
    end
    else
    begin
      pins_assigned_out  <= serial_port_enable_reg;
      clock_pin_out      <= sclk_reg;
      clock_pin_oe_n_out <= ~(serial_port_enable_reg & sync_reg & master_reg);
      data_pin_out       <= 1'b0;
      data_pin_oe_n_out  <= 1'b1;
      char_ready_out     <= serial_port_enable_reg & ~buf_empty;
    end
  end

endmodule

/* core/rx_status_control_map.vh */
// constants of the receive control and status block: offsets, fields, resets, timing
// assumes it is included by bare name from the design files under core/
//
// What this block does
// - port enable assigns both serial pins; clear holds the receiver in reset
// - nine-bit select picks 9-bit characters, otherwise 8-bit characters
// - sync master: single enable starts one receive, cleared by hardware when done
// - async mode: continuous enable switches the receiver on and off
// - sync mode: continuous enable keeps receiving and overrides single enable
// - async 9-bit address detect keeps only characters whose ninth bit is one
// - without address detect every character is kept, ninth bit usable as parity
// - framing error flag follows the buffered character, refreshed on buffer read
// - overrun flag is set on overrun and cleared only by clearing continuous enable or port enable
// - ninth received bit is read-only status; no parity computed in hardware
`ifndef RX_STATUS_CONTROL_MAP_VH
`define RX_STATUS_CONTROL_MAP_VH

// ************************************************
// register byte offsets
// ************************************************
`define OFF_STATUS_CONTROL   8'h00
`define OFF_DATA_BUFFER      8'h04
`define OFF_MODE             8'h08
`define OFF_BAUD_DIVISOR     8'h0c
`define OFF_ENGINE_STATUS    8'h10

// ************************************************
// receive_status_control fields
// ************************************************
`define BIT_PORT_ENABLE      7
`define BIT_NINE_SELECT      6
`define BIT_SINGLE_ENABLE    5
`define BIT_CONT_ENABLE      4
`define BIT_ADDR_DETECT      3
`define BIT_FRAMING_ERROR    2
`define BIT_OVERRUN_ERROR    1
`define BIT_NINTH_BIT        0

// ************************************************
// mode register fields
// ************************************************
`define BIT_MODE_SYNC        0
`define BIT_MODE_MASTER      1

// ************************************************
// reset values and timing
// ************************************************
`define RESET_STATUS_CONTROL 8'h00
`define RESET_MODE           2'h0
`define RESET_BAUD_DIVISOR   16'h0009
`define CHAR_BITS_SHORT      4'h8
`define CHAR_BITS_LONG       4'h9

`endif

/* core/rx_char_memory.v */
// small receive character store with a registered read port
// assumes one write and one read address per cycle, same clock as the writer
`timescale 1ns/1ps
module rx_char_memory #(
  parameter WIDTH  = 10,
  parameter ADDR_W = 1
)(
  input  wire              mclk_in,     // system clock
  input  wire              wr_en_in,    // write strobe
  input  wire [ADDR_W-1:0] wr_addr_in,  // write address
  input  wire [WIDTH-1:0]  wr_data_in,  // write data
  input  wire [ADDR_W-1:0] rd_addr_in,  // read address
  output reg  [WIDTH-1:0]  rd_data_out  // registered read data
);

  reg [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

  always @(posedge mclk_in)
  begin
    if (wr_en_in)
    begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end

endmodule

/* tb/rx_status_control_assertions.sv */
// checker of the receive block: apb answer, pin ownership, char flag
// assumes bind to rx_status_control, answer after one wait state
`timescale 1ns/1ps
module rx_status_control_assertions (
  input wire logic        mclk_in,            // clock
  input wire logic        rst_in,             // reset
  input wire logic [7:0]  paddr_in,           // address
  input wire logic        psel_in,            // select
  input wire logic        penable_in,         // enable
  input wire logic        pwrite_in,          // direction
  input wire logic [31:0] pwdata_in,          // write data
  input wire logic [31:0] prdata_out,         // read data
  input wire logic        pready_out,         // ready
  input wire logic        pslverr_out,        // error
  input wire logic        data_pin_oe_n_out,  // data enable
  input wire logic        clock_pin_oe_n_out, // clock enable
  input wire logic        pins_assigned_out,  // pins owned
  input wire logic        char_ready_out      // char held
);
  // ************
  // properties
  // ************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  wire ctl_wr = psel_in && penable_in && pready_out && pwrite_in && paddr_in == 8'h00;
  chk_ready_one_wait: assert property (psel_in && $rose(penable_in) |-> !pready_out ##1 pready_out)
    else $error("ready not one cycle after access");
  chk_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  chk_err_map: assert property (pready_out |-> pslverr_out == !(paddr_in == 8'h00 ||
    paddr_in == 8'h04 || paddr_in == 8'h08 || paddr_in == 8'h0c || paddr_in == 8'h10))
    else $error("error does not match address map");
  chk_err_rdata: assert property (pready_out && pslverr_out |-> prdata_out == 32'h0)
    else $error("unmapped read not zero");
  chk_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside answer");
  chk_pins_follow: assert property (ctl_wr |-> ##2 pins_assigned_out == $past(pwdata_in[7], 2))
    else $error("pins do not follow port enable");
  chk_clock_owner: assert property (!pins_assigned_out && !$past(pins_assigned_out)
    |-> clock_pin_oe_n_out)
    else $error("clock pin driven while port off");
  chk_ready_port: assert property (!pins_assigned_out && !$past(pins_assigned_out)
    |-> !char_ready_out)
    else $error("char flag while port off");
  chk_data_released: assert property (data_pin_oe_n_out)
    else $error("data pin driven");
  cover property (ctl_wr);
  cover property ($rose(char_ready_out));
  cover property (pready_out && pslverr_out);
endmodule
bind rx_status_control rx_status_control_assertions u_chk (
  .mclk_in, .rst_in, .paddr_in, .psel_in, .penable_in, .pwrite_in, .pwdata_in,
  .prdata_out, .pready_out, .pslverr_out, .data_pin_oe_n_out, .clock_pin_oe_n_out,
  .pins_assigned_out, .char_ready_out
);

/* tb/serial_peer_model.sv */
// serial peer: an asynchronous terminal, or a clock source for sync slave reception
// assumes the bench sets the receiver divisor to match the bit time
`timescale 1ns/1ps
module serial_peer #(
  parameter BIT_NS = 160
)(
  output logic line_out, // data pin level
  output logic sclk_out  // link clock level, idles low outside frames
);
  // ************
  // frame sender
  // ************
  initial line_out = 1'b1;
  initial sclk_out = 1'b0;
  // sync slave frame: data changes while the clock is low, taken as it rises
  task automatic send_sync(input logic [7:0] val);
    integer i;
    begin
      #2;
      for (i = 0; i < 8; i = i + 1)
      begin
        line_out = val[i];
        #(BIT_NS / 2);
        sclk_out = 1'b1;
        #(BIT_NS / 2);
        sclk_out = 1'b0;
      end
      line_out = 1'b1;
    end
  endtask
  task automatic send(input logic [8:0] val, input logic nine, input logic stop_ok);
    integer i;
    begin
      // keep line changes off the receiver's clock edges
      #2;
      line_out = 1'b0;
      #BIT_NS;
      for (i = 0; i < (nine ? 9 : 8); i = i + 1)
      begin
        line_out = val[i];
        #BIT_NS;
      end
      line_out = stop_ok;
      #BIT_NS;
      line_out = 1'b1;
      #BIT_NS;
    end
  endtask
endmodule

/* tb/rx_status_control_tb_top.sv */
// self-checking bench of the receive block over apb with a serial peer
// assumes divisor 19 gives 160 ns bits, as the peer sends them
`timescale 1ns/1ps
module rx_status_control_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        line;
  logic        sclk_oe_n;
  logic        pins;
  logic        ready;
  logic [31:0] rd;
  logic        er;
  logic        peer_clk;
  logic        dout;
  logic        doe_n;
  logic        sclk_pin;
  integer      sclk_edges = 0;
  integer      fail_count = 0;
  integer      checked = 0;
  integer      cyc = 0;
  always #4 clk = ~clk;
  rx_status_control DUT (
    .mclk_in(clk), .rst_in(rst), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .data_pin_in(line), .data_pin_out(dout), .data_pin_oe_n_out(doe_n),
    .clock_pin_in(peer_clk), .clock_pin_out(sclk_pin), .clock_pin_oe_n_out(sclk_oe_n),
    .pins_assigned_out(pins), .char_ready_out(ready)
  );
  serial_peer peer (.line_out(line), .sclk_out(peer_clk));
  always @(posedge sclk_pin)
  begin
    sclk_edges = sclk_edges + 1;
  end
  // ************
  // helpers
  // ************
  task end_sim;
    begin
      if (fail_count == 0 && checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp)
      begin
        fail_count = fail_count + 1;
        $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
      begin
        @(posedge clk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
    end
  endtask
  task pop(input logic [7:0] exp);
    begin
      apb(1'b0, 8'h04, 32'h0);
      chk(rd[7:0], exp);
    end
  endtask
  task wait_char;
    integer n;
    begin
      n = 0;
      @(posedge clk);
      while (ready !== 1'b1 && n < 600)
      begin
        @(posedge clk);
        n = n + 1;
      end
      if (ready !== 1'b1)
      begin
        fail_count = fail_count + 1;
        $display("[FAIL] t=%0t got %h exp %h", $time, ready, 1'b1);
      end
    end
  endtask
  // ************
  // scenarios
  // ************
  task t_reset;
    begin
      rdc(8'h00, 32'h0);
      chk(pins, 1'b0);
      chk(doe_n, 1'b1);
      chk(dout, 1'b0);
      chk(sclk_oe_n, 1'b1);
      chk(sclk_pin, 1'b0);
      rdc(8'h08, 32'h0);
      chk(er, 1'b0);
      apb(1'b0, 8'h10, 32'h0);
      chk(er, 1'b0);
      rdc(8'h20, 32'h0);
      chk(er, 1'b1);
      rdc(8'h0c, 32'h9);
      apb(1'b1, 8'h0c, 32'h13);
    end
  endtask
  task t_async;
    begin
      apb(1'b1, 8'h00, 32'h98);
      peer.send(9'h0a5, 1'b0, 1'b1);
      wait_char;
      chk(pins, 1'b1);
      rdc(8'h00, 32'h98);
      pop(8'ha5);
      peer.send(9'h05a, 1'b0, 1'b0);
      wait_char;
      rdc(8'h00, 32'h9c);
      pop(8'h5a);
      peer.send(9'h0c3, 1'b0, 1'b1);
      wait_char;
      rdc(8'h00, 32'h98);
      pop(8'hc3);
    end
  endtask
  task t_address;
    begin
      apb(1'b1, 8'h00, 32'hd8);
      peer.send(9'h03c, 1'b1, 1'b1);
      repeat (40) @(posedge clk);
      chk(ready, 1'b0);
      peer.send(9'h13c, 1'b1, 1'b1);
      wait_char;
      rdc(8'h00, 32'hd9);
      pop(8'h3c);
      apb(1'b1, 8'h00, 32'hd0);
      peer.send(9'h055, 1'b1, 1'b1);
      wait_char;
      rdc(8'h00, 32'hd0);
      pop(8'h55);
    end
  endtask
  task t_overrun;
    begin
      apb(1'b1, 8'h00, 32'h90);
      peer.send(9'h011, 1'b0, 1'b1);
      peer.send(9'h022, 1'b0, 1'b1);
      peer.send(9'h033, 1'b0, 1'b1);
      wait_char;
      rdc(8'h00, 32'h92);
      pop(8'h11);
      pop(8'h22);
      apb(1'b1, 8'h00, 32'h80);
      rdc(8'h00, 32'h80);
    end
  endtask
  task t_sync;
    integer n;
    begin
      n = 0;
      apb(1'b1, 8'h08, 32'h3);
      apb(1'b1, 8'h00, 32'hb0);
      wait_char;
      rdc(8'h00, 32'hb0);
      chk(sclk_oe_n, 1'b0);
      pop(8'hff);
      apb(1'b1, 8'h00, 32'h0);
      sclk_edges = 0;
      apb(1'b1, 8'h00, 32'ha0);
      rd = 32'h20;
      while (rd[5] !== 1'b0 && n < 200)
      begin
        apb(1'b0, 8'h00, 32'h0);
        n = n + 1;
      end
      chk(rd, 32'h80);
      chk(sclk_edges, 32'h8);
      pop(8'hff);
      apb(1'b1, 8'h00, 32'h0);
      @(posedge clk);
      chk(pins, 1'b0);
      chk(ready, 1'b0);
      apb(1'b1, 8'h08, 32'h0);
    end
  endtask
  task t_slave;
    begin
      apb(1'b1, 8'h08, 32'h1);
      apb(1'b1, 8'h00, 32'ha0);
      peer.send_sync(8'h69);
      repeat (8) @(posedge clk);
      chk(ready, 1'b0);
      chk(sclk_oe_n, 1'b1);
      apb(1'b1, 8'h00, 32'h90);
      peer.send_sync(8'h69);
      wait_char;
      rdc(8'h00, 32'h90);
      pop(8'h69);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h08, 32'h0);
    end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      fail_count = fail_count + 1;
      end_sim;
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_async;
    t_address;
    t_overrun;
    t_sync;
    t_slave;
    end_sim;
  end
endmodule
